// *** crg_pkg.sv ***
// crg_pkg: constants, selector and operation enums, carrier structs for the core control registers
// assumes one 250 MHz clock; data operands are 24-bit words, immediates and condition codes are 8 bits
package crg_pkg;
  localparam int WORD_W   = 24;
  localparam int BYTE_W   = 8;
  localparam int NUM_AGU  = 8;
  localparam int STK_DEPTH = 16;
  localparam int STK_AW   = 4;
  localparam logic [23:0] OPMODE_DEF_MASK = 24'hFFFFFF;
  localparam logic [23:0] VBASE_DEF_MASK  = 24'hFFFF00;
  localparam logic [23:0] WORD_ONE        = 24'h000001;
  localparam logic [23:0] WORD_ZERO       = 24'h000000;
  localparam logic [15:0] BYTE_FILL_ZERO  = 16'h0000;
  localparam logic [15:0] BYTE_FILL_ONES  = 16'hFFFF;
  localparam int CC_CARRY_BIT = 0;

  typedef enum logic [3:0] {
    SEL_ADDR, SEL_OFFSET, SEL_MODIFIER, SEL_OPMODE, SEL_VBASE, SEL_STATUS,
    SEL_MODE, SEL_CC, SEL_LCNT, SEL_LADDR, SEL_SSIZE, SEL_SSHIGH, SEL_SSLOW,
    SEL_SPTR, SEL_PC
  } crg_sel_t;

  typedef enum logic [5:0] {
    OP_ADD, OP_SUB, OP_MUL, OP_CMP, OP_SHIFT1, OP_CLR, OP_NEG, OP_RND, OP_TST,
    OP_TFR, OP_ARITH_IMM, OP_SHIFT_MB, OP_MUL_MIXED, OP_INC, OP_DEC, OP_DIV,
    OP_NORM, OP_DMAC, OP_CMPU, OP_TCC,
    OP_AND, OP_OR, OP_NOT, OP_LSR1, OP_ROL, OP_EOR, OP_LSL, OP_ROR, OP_CLB,
    OP_FIELD, OP_MERGE, OP_LOGIC_MB, OP_LOGIC_IMM, OP_ANDI, OP_ORI,
    OP_BCHG, OP_BCLR, OP_BSET, OP_BTST
  } crg_op_t;

  typedef enum logic [1:0] { TGT_MODE, TGT_CC, TGT_CHIPMODE } crg_tgt_t;

  typedef struct packed {
    logic        valid;
    logic        we;
    crg_sel_t    sel;
    logic [2:0]  idx;
    logic [23:0] wdata;
  } crg_reg_req_t;

  typedef struct packed {
    logic        valid;
    crg_op_t     op;
    logic        cond;
    logic        parMove;
    logic [7:0]  ccIn;
    logic [7:0]  imm;
    crg_tgt_t    tgt;
    logic [23:0] memIn;
    logic [4:0]  bitIdx;
  } crg_op_req_t;

  typedef struct packed {
    logic        push;
    logic        pop;
    logic        loopPair;
    logic        pcStep;
  } crg_flow_t;

  typedef struct packed {
    logic        valid;
    logic        signExt;
    logic [23:0] word;
  } crg_byte_req_t;
endpackage : crg_pkg

// *** crg_core_regs.sv ***
// crg_core_regs: control registers, address registers, system stack and op-group gate
// assumes requests are synchronous to clock and valid for one cycle each
`timescale 1ns/1ps
module crg_core_regs (
  input  wire logic                 clock,
  input  wire logic                 srst,
  input  crg_pkg::crg_reg_req_t     regReq,
  input  crg_pkg::crg_op_req_t      opReq,
  input  crg_pkg::crg_flow_t        flow,
  input  crg_pkg::crg_byte_req_t    byteReq,
  output logic [23:0]               regRData,
  output logic                      opDone,
  output logic                      opReject,
  output logic                      parMoveGo,
  output logic                      memWe,
  output logic [23:0]               memOut,
  output logic [23:0]               byteBus,
  output logic [23:0]               pcOut,
  output logic [23:0]               statusOut
);
  import crg_pkg::*;

  typedef struct packed {
    logic [NUM_AGU-1:0][WORD_W-1:0]   addrR;
    logic [NUM_AGU-1:0][WORD_W-1:0]   offR;
    logic [NUM_AGU-1:0][WORD_W-1:0]   modR;
    logic [WORD_W-1:0]                opMode;
    logic [WORD_W-1:0]                vbase;
    logic [WORD_W-1:0]                lcnt;
    logic [WORD_W-1:0]                laddr;
    logic [WORD_W-1:0]                ssize;
    logic [WORD_W-1:0]                sptr;
    logic [WORD_W-1:0]                pc;
    logic [BYTE_W-1:0]                extMode;
    logic [BYTE_W-1:0]                sysMode;
    logic [BYTE_W-1:0]                cc;
    logic [STK_DEPTH-1:0][2*WORD_W-1:0] stk;
    logic [WORD_W-1:0]                rdData;
    logic                             opDone;
    logic                             opReject;
    logic                             parMoveGo;
    logic                             memWe;
    logic [WORD_W-1:0]                memOut;
    logic [WORD_W-1:0]                byteBus;
  } crg_state_t;

  crg_state_t s_q;
  crg_state_t s_d;

  // parallel-move admission per operation
  function automatic logic parOk(input crg_op_t op);
    unique case (op)
      OP_ADD, OP_SUB, OP_MUL, OP_CMP, OP_SHIFT1, OP_CLR, OP_NEG, OP_RND,
      OP_TST, OP_TFR:                          parOk = 1'b1;
      OP_AND, OP_OR, OP_NOT, OP_LSR1, OP_ROL:  parOk = 1'b1;
      default:                                 parOk = 1'b0;
    endcase
  endfunction : parOk

  function automatic logic isBitOp(input crg_op_t op);
    isBitOp = (op == OP_BCHG) || (op == OP_BCLR) || (op == OP_BSET) || (op == OP_BTST);
  endfunction : isBitOp

  function automatic logic isCtrlImm(input crg_op_t op);
    isCtrlImm = (op == OP_ANDI) || (op == OP_ORI);
  endfunction : isCtrlImm

  function automatic logic [WORD_W-1:0] readReg(input crg_state_t st, input crg_sel_t sel,
                                                input logic [2:0] idx);
    logic [STK_AW-1:0] top;
    top = st.sptr[STK_AW-1:0];
    unique case (sel)
      SEL_ADDR:     readReg = st.addrR[idx];
      SEL_OFFSET:   readReg = st.offR[idx];
      SEL_MODIFIER: readReg = st.modR[idx];
      SEL_OPMODE:   readReg = st.opMode & OPMODE_DEF_MASK;
      SEL_VBASE:    readReg = st.vbase & VBASE_DEF_MASK;
      SEL_STATUS:   readReg = {st.extMode, st.sysMode, st.cc};
      SEL_MODE:     readReg = {BYTE_FILL_ZERO, st.sysMode};
      SEL_CC:       readReg = {BYTE_FILL_ZERO, st.cc};
      SEL_LCNT:     readReg = st.lcnt;
      SEL_LADDR:    readReg = st.laddr;
      SEL_SSIZE:    readReg = st.ssize;
      SEL_SSHIGH:   readReg = st.stk[top][2*WORD_W-1:WORD_W];
      SEL_SSLOW:    readReg = st.stk[top][WORD_W-1:0];
      SEL_SPTR:     readReg = st.sptr;
      SEL_PC:       readReg = st.pc;
      default:      readReg = WORD_ZERO;
    endcase
  endfunction : readReg

  always_comb begin
    logic [STK_AW-1:0] top;
    logic [STK_AW-1:0] nxt;
    logic              refuse;
    logic              testBit;
    s_d       = s_q;
    top       = s_q.sptr[STK_AW-1:0];
    nxt       = top + 1'b1;
    refuse    = 1'b0;
    testBit   = 1'b0;
    s_d.opDone    = 1'b0;
    s_d.opReject  = 1'b0;
    s_d.parMoveGo = 1'b0;
    s_d.memWe     = 1'b0;

    // read data reflects state before this cycle's write
    if (regReq.valid) begin
      s_d.rdData = readReg(s_q, regReq.sel, regReq.idx);
    end
    if (regReq.valid && regReq.we) begin
      unique case (regReq.sel)
        SEL_ADDR:     s_d.addrR[regReq.idx] = regReq.wdata;
        SEL_OFFSET:   s_d.offR[regReq.idx]  = regReq.wdata;
        SEL_MODIFIER: s_d.modR[regReq.idx]  = regReq.wdata;
        SEL_OPMODE:   s_d.opMode = regReq.wdata & OPMODE_DEF_MASK;
        SEL_VBASE:    s_d.vbase  = regReq.wdata & VBASE_DEF_MASK;
        SEL_STATUS:   {s_d.extMode, s_d.sysMode, s_d.cc} = regReq.wdata;
        SEL_MODE:     s_d.sysMode = regReq.wdata[BYTE_W-1:0];
        SEL_CC:       s_d.cc = regReq.wdata[BYTE_W-1:0];
        SEL_LCNT:     s_d.lcnt  = regReq.wdata;
        SEL_LADDR:    s_d.laddr = regReq.wdata;
        SEL_SSIZE:    s_d.ssize = regReq.wdata;
        SEL_SSHIGH:   s_d.stk[top][2*WORD_W-1:WORD_W] = regReq.wdata;
        SEL_SSLOW:    s_d.stk[top][WORD_W-1:0] = regReq.wdata;
        SEL_SPTR:     s_d.sptr = regReq.wdata;
        SEL_PC:       s_d.pc   = regReq.wdata;
        default:      s_d.sptr = s_q.sptr;
      endcase
    end

    // implicit program-counter advance over 24-bit program words
    if (flow.pcStep) begin
      s_d.pc = s_d.pc + WORD_ONE;
    end
    // push wins over pop when both arrive together
    if (flow.push) begin
      s_d.sptr = s_d.sptr + WORD_ONE;
      s_d.stk[nxt] = flow.loopPair ? {s_d.laddr, s_d.lcnt}
                                   : {s_d.pc, s_d.extMode, s_d.sysMode, s_d.cc};
    end else if (flow.pop) begin
      s_d.sptr = s_d.sptr - WORD_ONE;
      if (flow.loopPair) begin
        {s_d.laddr, s_d.lcnt} = s_q.stk[top];
      end else begin
        {s_d.pc, s_d.extMode, s_d.sysMode, s_d.cc} = s_q.stk[top];
      end
    end

    // low byte of a data word onto the data bus
    if (byteReq.valid) begin
      s_d.byteBus = {(byteReq.signExt && byteReq.word[BYTE_W-1]) ? BYTE_FILL_ONES
                     : BYTE_FILL_ZERO, byteReq.word[BYTE_W-1:0]};
    end

    // a move request on a non-parallel or conditional op refuses the whole op
    if (opReq.valid) begin
      refuse = opReq.parMove && (opReq.cond || !parOk(opReq.op));
      s_d.opReject = refuse;
      s_d.opDone   = !refuse;
      // operands are registers; buses carry only the granted move
      s_d.parMoveGo = !refuse && opReq.parMove;
      if (!refuse) begin
        if (isBitOp(opReq.op)) begin
          testBit = opReq.memIn[opReq.bitIdx];
          s_d.cc[CC_CARRY_BIT] = testBit;
          s_d.memOut = opReq.memIn;
          unique case (opReq.op)
            OP_BSET: s_d.memOut[opReq.bitIdx] = 1'b1;
            OP_BCLR: s_d.memOut[opReq.bitIdx] = 1'b0;
            OP_BCHG: s_d.memOut[opReq.bitIdx] = !testBit;
            default: s_d.memOut[opReq.bitIdx] = testBit;
          endcase
          s_d.memWe = (opReq.op != OP_BTST);
        end else if (isCtrlImm(opReq.op)) begin
          // acts on control bytes, ignores ccIn; the condition codes change only when the target is TGT_CC
          unique case (opReq.tgt)
            TGT_MODE: s_d.sysMode = (opReq.op == OP_ANDI) ? (s_d.sysMode & opReq.imm)
                                                          : (s_d.sysMode | opReq.imm);
            TGT_CC:   s_d.cc = (opReq.op == OP_ANDI) ? (s_d.cc & opReq.imm)
                                                     : (s_d.cc | opReq.imm);
            TGT_CHIPMODE: s_d.opMode[BYTE_W-1:0] = ((opReq.op == OP_ANDI)
                ? (s_d.opMode[BYTE_W-1:0] & opReq.imm)
                : (s_d.opMode[BYTE_W-1:0] | opReq.imm)) & OPMODE_DEF_MASK[BYTE_W-1:0];
            default:  s_d.cc = s_d.cc;
          endcase
        end else begin
          s_d.cc = opReq.ccIn;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign regRData  = s_q.rdData;
  assign opDone    = s_q.opDone;
  assign opReject  = s_q.opReject;
  assign parMoveGo = s_q.parMoveGo;
  assign memWe     = s_q.memWe;
  assign memOut    = s_q.memOut;
  assign byteBus   = s_q.byteBus;
  assign pcOut     = s_q.pc;
  assign statusOut = {s_q.extMode, s_q.sysMode, s_q.cc};

  property p_vbase_low;
    @(posedge clock) disable iff (srst)
      regReq.valid && regReq.sel == SEL_VBASE |=> regRData[BYTE_W-1:0] == 8'h00;
  endproperty
  a_vbase_low: assert property (p_vbase_low) else $error("vector base low byte not zero");
  property p_status_read;
    @(posedge clock) disable iff (srst)
      regReq.valid && regReq.sel == SEL_STATUS |=> regRData == $past(statusOut);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status word read mismatch");
  property p_cc_keeps;
    @(posedge clock) disable iff (srst)
      regReq.valid && regReq.we && regReq.sel == SEL_CC && !opReq.valid && !flow.pop
      |=> statusOut[23:8] == $past(statusOut[23:8]) && statusOut[7:0] == $past(regReq.wdata[7:0]);
  endproperty
  a_cc_keeps: assert property (p_cc_keeps) else $error("cc write disturbed status");
  property p_cond_refuse;
    @(posedge clock) disable iff (srst)
      opReq.valid && opReq.cond && opReq.parMove |=> opReject && !parMoveGo && !opDone;
  endproperty
  a_cond_refuse: assert property (p_cond_refuse) else $error("conditional move accepted");
  property p_bit_nomove;
    @(posedge clock) disable iff (srst)
      opReq.valid && opReq.parMove && opReq.op inside {OP_BCHG, OP_BCLR, OP_BSET, OP_BTST}
      |=> opReject ##1 !opReject;
  endproperty
  a_bit_nomove: assert property (p_bit_nomove) else $error("bit op took a move");
  property p_bit_carry;
    @(posedge clock) disable iff (srst)
      opReq.valid && !opReq.parMove && opReq.op inside {OP_BCHG, OP_BCLR, OP_BSET, OP_BTST}
      |=> statusOut[CC_CARRY_BIT] == $past(opReq.memIn[opReq.bitIdx]);
  endproperty
  a_bit_carry: assert property (p_bit_carry) else $error("carry not the tested bit");
  property p_byte_sign;
    @(posedge clock) disable iff (srst)
      byteReq.valid && byteReq.signExt && byteReq.word[7] |=> byteBus[23:8] == 16'hFFFF;
  endproperty
  a_byte_sign: assert property (p_byte_sign) else $error("byte not sign extended");
  property p_push_ptr;
    @(posedge clock) disable iff (srst)
      flow.push && !(regReq.valid && regReq.we) |=> s_q.sptr == $past(s_q.sptr) + 24'h000001;
  endproperty
  a_push_ptr: assert property (p_push_ptr) else $error("push did not advance pointer");
  property p_par_grant;
    @(posedge clock) disable iff (srst)
      opReq.valid && opReq.parMove && !opReq.cond && opReq.op inside {OP_ADD, OP_AND}
      |=> parMoveGo && opDone;
  endproperty
  a_par_grant: assert property (p_par_grant) else $error("legal move refused");
  c_bset: cover property (@(posedge clock) opReq.valid && opReq.op == OP_BSET ##1 memWe);
  c_reject: cover property (@(posedge clock) opReject);
  c_push_pop: cover property (@(posedge clock) flow.push ##1 flow.pop);
  c_byte_neg: cover property (@(posedge clock) byteReq.valid && byteReq.signExt ##1 byteBus[23]);
  c_par_move: cover property (@(posedge clock) parMoveGo);
  property p_pop_ptr;
    @(posedge clock) disable iff (srst)
      flow.pop && !flow.push && !(regReq.valid && regReq.we) |=> s_q.sptr == $past(s_q.sptr) - 24'h000001;
  endproperty
  a_pop_ptr: assert property (p_pop_ptr) else $error("pop did not retreat pointer");
  property p_pc_step;
    @(posedge clock) disable iff (srst)
      flow.pcStep && !(regReq.valid && regReq.we) && !flow.pop |=> pcOut == $past(pcOut) + 24'h000001;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("program counter did not step");
  property p_arith_cc;
    @(posedge clock) disable iff (srst)
      opReq.valid && !opReq.cond && opReq.op == OP_ADD |=> statusOut[7:0] == $past(opReq.ccIn);
  endproperty
  a_arith_cc: assert property (p_arith_cc) else $error("arithmetic codes not taken");
  property p_refuse_still;
    @(posedge clock) disable iff (srst)
      opReq.valid && opReq.parMove && opReq.op == OP_EOR && !(regReq.valid && regReq.we) && !flow.pop
      |=> opReject && statusOut == $past(statusOut);
  endproperty
  a_refuse_still: assert property (p_refuse_still) else $error("refused op changed status");
  property p_ori_mode;
    @(posedge clock) disable iff (srst)
      opReq.valid && !opReq.parMove && opReq.op == OP_ORI && opReq.tgt == TGT_MODE
      && !(regReq.valid && regReq.we) && !flow.pop
      |=> (statusOut[15:8] & $past(opReq.imm)) == $past(opReq.imm);
  endproperty
  a_ori_mode: assert property (p_ori_mode) else $error("or-immediate missed mode byte");
  property p_byte_zero;
    @(posedge clock) disable iff (srst)
      byteReq.valid && !byteReq.signExt |=> byteBus[23:8] == 16'h0000;
  endproperty
  a_byte_zero: assert property (p_byte_zero) else $error("byte not zero extended");
  property p_mode_keeps;
    @(posedge clock) disable iff (srst)
      regReq.valid && regReq.we && regReq.sel == SEL_MODE && !opReq.valid && !flow.pop
      |=> statusOut[23:16] == $past(statusOut[23:16]) && statusOut[7:0] == $past(statusOut[7:0])
          && statusOut[15:8] == $past(regReq.wdata[7:0]);
  endproperty
  a_mode_keeps: assert property (p_mode_keeps) else $error("mode write disturbed status");
endmodule : crg_core_regs

// *** tb_core_control_regs_and_op_groups.sv ***
// tb_core_control_regs_and_op_groups: self-checking bench for crg_core_regs
// assumes the design's own assertions; drives ports directly at rising edges
`timescale 1ns/1ps
module tb_core_control_regs_and_op_groups;
  import crg_pkg::*;
  logic          clock;
  logic          srst;
  crg_reg_req_t  regReq;
  crg_op_req_t   opReq;
  crg_flow_t     flow;
  crg_byte_req_t byteReq;
  logic [23:0]   regRData, memOut, byteBus, pcOut, statusOut;
  logic          opDone, opReject, parMoveGo, memWe;
  int            fail_count = 0;
  int            tests_run  = 0;
  logic [7:0]    expCc;
  crg_op_t       o;
  logic          cap;

  crg_core_regs crg_core_regs_i (
    .clock     (clock),
    .srst      (srst),
    .regReq    (regReq),
    .opReq     (opReq),
    .flow      (flow),
    .byteReq   (byteReq),
    .regRData  (regRData),
    .opDone    (opDone),
    .opReject  (opReject),
    .parMoveGo (parMoveGo),
    .memWe     (memWe),
    .memOut    (memOut),
    .byteBus   (byteBus),
    .pcOut     (pcOut),
    .statusOut (statusOut)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp, input string m);
    chk_word({23'h0, got}, {23'h0, exp}, m);
  endtask : chk_bit

  task automatic reg_wr(input crg_sel_t s, input logic [2:0] i, input logic [23:0] d);
    @(posedge clock);
    regReq <= '{1'b1, 1'b1, s, i, d};
    @(posedge clock);
    regReq.valid <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input crg_sel_t s, input logic [2:0] i, output logic [23:0] d);
    @(posedge clock);
    regReq <= '{1'b1, 1'b0, s, i, 24'h000000};
    @(posedge clock);
    regReq.valid <= 1'b0;
    #1 d = regRData;
  endtask : reg_rd

  task automatic rd_chk(input crg_sel_t s, input logic [2:0] i, input logic [23:0] e);
    logic [23:0] v;
    reg_rd(s, i, v);
    chk_word(v, e, s.name());
  endtask : rd_chk

  task automatic do_op(input crg_op_t op, input logic cd, input logic pm, input logic [7:0] cc,
                       input logic [7:0] im, input crg_tgt_t tg, input logic [23:0] mem,
                       input logic [4:0] b);
    @(posedge clock);
    opReq <= '{1'b1, op, cd, pm, cc, im, tg, mem, b};
    @(posedge clock);
    opReq.valid <= 1'b0;
    #1;
  endtask : do_op

  task automatic do_flow(input logic ps, input logic pp, input logic lp);
    @(posedge clock);
    flow <= '{ps, pp, lp, 1'b0};
    @(posedge clock);
    flow <= '0;
    #1;
  endtask : do_flow

  task automatic test_end(input string n);
    $display("test %s done, checks %0d, mismatches %0d", n, tests_run, fail_count);
  endtask : test_end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  initial begin
    #20000;
    fail_count++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    srst = 1'b1;
    regReq = '0;
    opReq = '0;
    flow = '0;
    byteReq = '0;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    rd_chk(SEL_STATUS, 3'h0, 24'h000000);
    for (int i = 0; i < NUM_AGU; i++) begin
      reg_wr(SEL_ADDR, i[2:0], 24'hA00000 | 24'(i));
      reg_wr(SEL_OFFSET, i[2:0], 24'h5B0000 | 24'(i));
      reg_wr(SEL_MODIFIER, i[2:0], 24'hFFFF00 | 24'(i));
    end
    for (int i = 0; i < NUM_AGU; i++) begin
      rd_chk(SEL_ADDR, i[2:0], 24'hA00000 | 24'(i));
      rd_chk(SEL_OFFSET, i[2:0], 24'h5B0000 | 24'(i));
      rd_chk(SEL_MODIFIER, i[2:0], 24'hFFFF00 | 24'(i));
    end
    test_end("address regs");
    reg_wr(SEL_OPMODE, 3'h0, 24'hC35A96);
    rd_chk(SEL_OPMODE, 3'h0, 24'hC35A96 & OPMODE_DEF_MASK);
    reg_wr(SEL_VBASE, 3'h0, 24'h1234FF);
    rd_chk(SEL_VBASE, 3'h0, 24'h123400);
    reg_wr(SEL_VBASE, 3'h0, 24'h5A0000);
    rd_chk(SEL_VBASE, 3'h0, 24'h5A0000);
    reg_wr(SEL_STATUS, 3'h0, 24'hE1B27C);
    rd_chk(SEL_STATUS, 3'h0, 24'hE1B27C);
    rd_chk(SEL_MODE, 3'h0, 24'h0000B2);
    rd_chk(SEL_CC, 3'h0, 24'h00007C);
    reg_wr(SEL_MODE, 3'h0, 24'hFFFF30);
    rd_chk(SEL_STATUS, 3'h0, 24'hE1307C);
    reg_wr(SEL_CC, 3'h0, 24'hFFFF81);
    rd_chk(SEL_STATUS, 3'h0, 24'hE13081);
    reg_wr(SEL_LCNT, 3'h0, 24'hFEDCBA);
    reg_wr(SEL_LADDR, 3'h0, 24'h00ABCD);
    reg_wr(SEL_SSIZE, 3'h0, 24'h800001);
    reg_wr(SEL_PC, 3'h0, 24'h7FFFFE);
    rd_chk(SEL_LCNT, 3'h0, 24'hFEDCBA);
    rd_chk(SEL_LADDR, 3'h0, 24'h00ABCD);
    rd_chk(SEL_SSIZE, 3'h0, 24'h800001);
    rd_chk(SEL_PC, 3'h0, 24'h7FFFFE);
    chk_word(pcOut, 24'h7FFFFE, "pcOut");
    test_end("control");
    // push program counter over status, then loop pair over it
    do_flow(1'b1, 1'b0, 1'b0);
    rd_chk(SEL_SSHIGH, 3'h0, 24'h7FFFFE);
    rd_chk(SEL_SSLOW, 3'h0, 24'hE13081);
    do_flow(1'b1, 1'b0, 1'b1);
    rd_chk(SEL_SSHIGH, 3'h0, 24'h00ABCD);
    rd_chk(SEL_SSLOW, 3'h0, 24'hFEDCBA);
    rd_chk(SEL_SPTR, 3'h0, 24'h000002);
    do_flow(1'b0, 1'b1, 1'b1);
    reg_wr(SEL_PC, 3'h0, 24'h000010);
    reg_wr(SEL_STATUS, 3'h0, 24'h000000);
    do_flow(1'b0, 1'b1, 1'b0);
    chk_word(pcOut, 24'h7FFFFE, "pop pc");
    chk_word(statusOut, 24'hE13081, "pop status");
    rd_chk(SEL_SPTR, 3'h0, 24'h000000);
    @(posedge clock);
    flow <= '{1'b0, 1'b0, 1'b0, 1'b1};
    @(posedge clock);
    flow <= '0;
    #1 chk_word(pcOut, 24'h7FFFFF, "pc step");
    test_end("stack");
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      byteReq <= '{1'b1, k[0], 24'h5A7F80};
      @(posedge clock);
      byteReq.valid <= 1'b0;
      #1 chk_word(byteBus, k[0] ? 24'hFFFF80 : 24'h000080, "byte");
    end
    test_end("byte");
    expCc = 8'h81;
    for (int i = 0; i <= int'(OP_BTST); i++) begin
      o = crg_op_t'(i);
      cap = (i <= int'(OP_TFR)) || (o inside {OP_AND, OP_OR, OP_NOT, OP_LSR1, OP_ROL});
      do_op(o, 1'b0, 1'b1, 8'(i) ^ 8'hA5, 8'hFF, TGT_CC, 24'h000000, 5'h00);
      chk_bit(opReject, !cap, o.name());
      chk_bit(opDone, cap, o.name());
      chk_bit(parMoveGo, cap, o.name());
      if (cap) expCc = 8'(i) ^ 8'hA5;
      chk_word(statusOut, {16'hE130, expCc}, "cc");
      do_op(o, 1'b1, 1'b1, 8'h00, 8'hFF, TGT_CC, 24'h000000, 5'h00);
      chk_bit(opReject, 1'b1, "cond move");
    end
    test_end("groups");
    do_op(OP_ORI, 1'b0, 1'b0, 8'h00, 8'h0C, TGT_MODE, 24'h000000, 5'h00);
    rd_chk(SEL_MODE, 3'h0, 24'h00003C);
    do_op(OP_ANDI, 1'b0, 1'b0, 8'h00, 8'h0F, TGT_CHIPMODE, 24'h000000, 5'h00);
    rd_chk(SEL_OPMODE, 3'h0, 24'hC35A06);
    test_end("control ops");
    do_op(OP_BCLR, 1'b0, 1'b0, 8'h00, 8'h00, TGT_CC, 24'h000020, 5'h05);
    chk_bit(memWe, 1'b1, "bclr we");
    chk_word(memOut, 24'h000000, "bclr");
    chk_bit(statusOut[CC_CARRY_BIT], 1'b1, "bclr c");
    do_op(OP_BSET, 1'b0, 1'b0, 8'h00, 8'h00, TGT_CC, 24'h000000, 5'h17);
    chk_word(memOut, 24'h800000, "bset");
    chk_bit(statusOut[CC_CARRY_BIT], 1'b0, "bset c");
    do_op(OP_BCHG, 1'b0, 1'b0, 8'h00, 8'h00, TGT_CC, 24'h123456, 5'h01);
    chk_word(memOut, 24'h123454, "bchg");
    chk_bit(statusOut[CC_CARRY_BIT], 1'b1, "bchg c");
    do_op(OP_BTST, 1'b0, 1'b0, 8'h00, 8'h00, TGT_CC, 24'h123456, 5'h00);
    chk_bit(memWe, 1'b0, "btst we");
    chk_bit(statusOut[CC_CARRY_BIT], 1'b0, "btst c");
    test_end("bits");
    end_sim();
  end
endmodule : tb_core_control_regs_and_op_groups
